/* data_word_ram.sv */
// Data memory with one write port and one registered read port.
`timescale 1ns/1ps
module data_word_ram
	import tw_decode_pkg::*;
#(
	parameter int WIDTH = WORD_W,
	parameter int DEPTH = DMEM_DEPTH,
	parameter int AW    = DADDR_W
)
(
	// Clock.
	input  wire logic             ref_clk,
	// Write port.
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	// Read port.
	input  wire logic             rd_en,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge ref_clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rd_en)
			rd_data <= mem[rd_addr];
	end
endmodule

/* prog_ram_model.sv */
// Behavioural program RAM on the far side of the program bus.
`timescale 1ns/1ps
module prog_ram_model
	import tw_decode_pkg::*;
(
	// Clock.
	input  wire logic              ref_clk,
	// Program bus.
	input  wire logic [PC_W-1:0]   prog_addr,
	input  wire logic [WORD_W-1:0] prog_data_out,
	input  wire logic              prog_data_oe,
	input  wire logic              memory_enable_n,
	input  wire logic              write_enable_n,
	output logic      [WORD_W-1:0] prog_data_in
);
	logic [WORD_W-1:0] mem [2**PC_W];
	logic [WORD_W-1:0] last_q = 16'h0000;
	// While not enabled the bus shows the inverse of the last word read.
	assign prog_data_in = memory_enable_n ? ~last_q : mem[prog_addr];
	always @(posedge ref_clk)
	begin
		if (!memory_enable_n)
			last_q <= mem[prog_addr];
		// Every strobe with prog_data_oe high stores the word, the lowest addresses included.
		if (!write_enable_n && prog_data_oe)
			mem[prog_addr] <= prog_data_out;
	end
endmodule

/* table_write_and_acc_load_ops_test.sv */
// Self-checking testbench for the table-write and sum-load decoder.
`timescale 1ns/1ps
module table_write_and_acc_load_ops_test
	import tw_decode_pkg::*;
;
	logic               ref_clk = 1'b0;
	logic               arst_n = 1'b0;
	logic [PC_W-1:0]    prog_addr;
	logic [WORD_W-1:0]  prog_data_in;
	logic [WORD_W-1:0]  prog_data_out;
	logic               prog_data_oe;
	logic               memory_enable_n;
	logic               write_enable_n;
	logic               dmem_load_en = 1'b0;
	logic [DADDR_W-1:0] dmem_load_addr = 7'h00;
	logic [WORD_W-1:0]  dmem_load_data = 16'h0000;
	logic [SUM_W-1:0]   sum_register;
	logic               aux_pointer_select;
	int                 error_cnt = 0;
	int                 n_compared = 0;
	logic               run = 1'b0;
	logic [WORD_W-1:0]  dm [DMEM_DEPTH];
	logic [WORD_W-1:0]  prog [10] = '{16'h6605, 16'h657F, 16'h7809, 16'h7D0A, 16'h7D0B,
		16'h7F88, OP_CLEAR_SUM, 16'h66A1, 16'h6580, 16'h7888};
	logic [SUM_W-1:0]   exp_q [$];
	logic [39:0]        wr_q [$];
	logic [39:0]        wr_exp;
	logic [SUM_W-1:0]   last_sum;
	logic [PC_W-1:0]    prev_addr;
	logic               prev_men;
	logic               after_wr;

	initial
	begin
		forever #10 ref_clk = ~ref_clk;
	end

	table_write_decoder u_table_write_decoder (.ref_clk(ref_clk), .arst_n(arst_n),
		.prog_addr(prog_addr), .prog_data_in(prog_data_in), .prog_data_out(prog_data_out),
		.prog_data_oe(prog_data_oe), .memory_enable_n(memory_enable_n),
		.write_enable_n(write_enable_n), .dmem_load_en(dmem_load_en),
		.dmem_load_addr(dmem_load_addr), .dmem_load_data(dmem_load_data),
		.sum_register(sum_register), .aux_pointer_select(aux_pointer_select));
	prog_ram_model u_prog_ram_model (.ref_clk(ref_clk), .prog_addr(prog_addr),
		.prog_data_out(prog_data_out), .prog_data_oe(prog_data_oe),
		.memory_enable_n(memory_enable_n), .write_enable_n(write_enable_n),
		.prog_data_in(prog_data_in));

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("Mismatches %0d of %0d compared", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Reference model: runs the program on integers and fills the queues.
	task automatic model();
		logic [SUM_W-1:0]  s;
		logic [7:0]        aux [2];
		logic              ptr;
		logic [WORD_W-1:0] w;
		logic [WORD_W-1:0] d;
		s = SUM_RESET;
		aux[0] = AUX_RESET;
		aux[1] = AUX_RESET;
		ptr = 1'b0;
		for (int p = 0; p < 10; p++)
		begin
			w = prog[p];
			d = dm[w[7] ? aux[ptr][6:0] : w[6:0]];
			if (w == OP_CLEAR_SUM)
			begin
				s = SUM_RESET;
				exp_q.push_back(s);
			end
			else if (w[15:8] inside {OP_TABLE_WRITE, OP_XOR, OP_ZERO_LOAD_H, OP_ZERO_LOAD_L})
			begin
				if (w[7])
				begin
					aux[ptr] = aux[ptr] + w[5] - w[4];
					if (!w[3])
						ptr = w[0];
				end
				case (w[15:8])
					OP_ZERO_LOAD_L: s = {16'h0000, d};
					OP_ZERO_LOAD_H: s = {d, 16'h0000};
					OP_XOR: s[15:0] = s[15:0] ^ d;
					default: wr_q.push_back({p[11:0] + 12'h001, s[11:0], d});
				endcase
				if (w[15:8] != OP_TABLE_WRITE)
					exp_q.push_back(s);
			end
		end
	endtask

	always @(posedge ref_clk)
	begin
		if (run)
		begin
			if (sum_register !== last_sum)
			begin
				check("sum", sum_register, exp_q.size() ? exp_q.pop_front() : 'x);
				last_sum = sum_register;
			end
			if (write_enable_n === 1'b0)
			begin
				wr_exp = wr_q.size() ? wr_q.pop_front() : 'x;
				check("addr cycle", {prev_men, prev_addr}, {1'b0, wr_exp[39:28]});
				check("write", {memory_enable_n, prog_data_oe, prog_addr, prog_data_out},
					{2'b11, wr_exp[27:0]});
				after_wr = 1'b1;
			end
			else if (after_wr)
			begin
				check("refetch", {memory_enable_n, prog_addr}, {1'b0, wr_exp[39:28]});
				after_wr = 1'b0;
			end
		end
		prev_addr = prog_addr;
		prev_men = memory_enable_n;
	end

	initial
	begin
		repeat (1000) @(posedge ref_clk);
		error_cnt++;
		test_done();
	end

	initial
	begin
		void'($urandom(40));
		for (int r = 0; r < 2; r++)
		begin
			@(posedge ref_clk);
			arst_n <= 1'b0;
			run <= 1'b0;
			for (int i = 0; i < DMEM_DEPTH; i++)
				dm[i] = 16'($urandom()) | 16'h0001;
			dm[9] = dm[9] | 16'h0800;
			exp_q.delete();
			wr_q.delete();
			model();
			for (int i = 0; i < 2**PC_W; i++)
				u_prog_ram_model.mem[i] = (i < 10) ? prog[i] : 16'h0000;
			for (int i = 0; i < DMEM_DEPTH; i++)
			begin
				@(posedge ref_clk);
				dmem_load_en <= 1'b1;
				dmem_load_addr <= i[6:0];
				dmem_load_data <= dm[i];
			end
			@(posedge ref_clk);
			dmem_load_en <= 1'b0;
			repeat (12) @(posedge ref_clk);
			check("reset", {prog_addr, memory_enable_n, write_enable_n, prog_data_oe,
				sum_register, aux_pointer_select}, {PC_RESET, 3'b010, SUM_RESET, 1'b0});
			last_sum = SUM_RESET;
			after_wr = 1'b0;
			arst_n <= 1'b1;
			run <= 1'b1;
			repeat (60) @(posedge ref_clk);
			check("final sum", sum_register, {dm[0], dm[1]});
			check("ram word", u_prog_ram_model.mem[dm[9][11:0]], dm[11]);
			check("pointer", aux_pointer_select, 1'b0);
			check("left over", exp_q.size() + wr_q.size(), 0);
		end
		test_done();
	end
endmodule

/* table_write_decoder.sv */
// Instruction sequencer for table write, exclusive-OR, clear and zero-load accumulator ops.
// Overview of operation
// - Table write saves PC+1 on stack, jumps to sum, writes word, restores PC.
// - Table write is one word, three cycles after an opcode prefetch with enable low.
// - During the prefetch the previous instruction still executes.
// - Cycle one: enable low, next address out, push PC, load PC from sum bits.
// - Cycle two: write strobe low, PC on address, data word driven, pop PC.
// - Cycle three: enable low and the following opcode is prefetched.
// - Exclusive-OR changes only the low sum half with the data word, one cycle.
// - Clear sets the whole sum register to zero in one cycle.
// - Zero-load-high puts the word in the upper half, lower half zero.
// - Zero-load-low puts the word unsigned in the lower half, upper zero.
// - Operands use a 7-bit direct address or current aux register, optional new pointer.
`timescale 1ns/1ps
module table_write_decoder
	import tw_decode_pkg::*;
#(
	parameter int STACK_D = STACK_DEPTH
)
(
	// Clock and reset.
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	// Program memory bus.
	output logic      [PC_W-1:0]   prog_addr,
	input  wire logic [WORD_W-1:0] prog_data_in,
	output logic      [WORD_W-1:0] prog_data_out,
	output logic                   prog_data_oe,
	output logic                   memory_enable_n,
	output logic                   write_enable_n,
	// Data memory load port.
	input  wire logic              dmem_load_en,
	input  wire logic [DADDR_W-1:0] dmem_load_addr,
	input  wire logic [WORD_W-1:0] dmem_load_data,
	// Visible core state.
	output logic      [SUM_W-1:0]  sum_register,
	output logic                   aux_pointer_select
);
	seq_state_t         state_reg;
	seq_state_t         state_next;
	logic [PC_W-1:0]    pc_reg;
	logic [WORD_W-1:0]  ir_reg;
	logic [SUM_W-1:0]   sum_reg;
	logic [PC_W-1:0]    stack_reg [STACK_D];
	logic [AUX_W-1:0]   aux_reg [2];
	logic [AUX_W-1:0]   aux_next [2];
	logic               ptr_reg;
	logic               ptr_next;
	logic [WORD_W-1:0]  dmem_word;
	logic [7:0]         ir_op;
	logic               is_table_write;
	logic               is_mem_op;
	logic               exec_now;
	logic               exec_mem;
	logic               fetch_now;
	logic               fetch_tw;
	logic [DADDR_W-1:0] rd_addr;
	logic [AUX_W-1:0]   fetch_aux;

	assign ir_op          = ir_reg[OP_HI:OP_LO];
	assign is_table_write = (ir_op == OP_TABLE_WRITE);
	assign is_mem_op      = is_table_write || (ir_op == OP_XOR)
		|| (ir_op == OP_ZERO_LOAD_H) || (ir_op == OP_ZERO_LOAD_L);
	assign fetch_tw       = (prog_data_in[OP_HI:OP_LO] == OP_TABLE_WRITE);
	assign exec_now       = (state_reg == ST_RUN);
	assign exec_mem       = (exec_now && is_mem_op) || (state_reg == ST_TW_ADDR);
	assign fetch_now      = (state_reg == ST_RUN) || (state_reg == ST_FILL);

	// Bus strobes; the address bus always shows the program counter.
	assign prog_addr       = pc_reg;
	assign memory_enable_n = (state_reg == ST_TW_WRITE);
	assign write_enable_n  = (state_reg != ST_TW_WRITE);
	assign prog_data_oe    = (state_reg == ST_TW_WRITE);
	assign prog_data_out   = dmem_word;
	assign sum_register    = sum_reg;
	assign aux_pointer_select = ptr_reg;

	// Pointer update of the executing instruction, forwarded to the next operand fetch.
	always_comb
	begin
		aux_next = aux_reg;
		ptr_next = ptr_reg;
		if (exec_mem && ir_reg[IND_BIT])
		begin
			if (ir_reg[INC_BIT])
				aux_next[ptr_reg] = aux_reg[ptr_reg] + 8'h01;
			else if (ir_reg[DEC_BIT])
				aux_next[ptr_reg] = aux_reg[ptr_reg] - 8'h01;
			if (!ir_reg[KEEP_PTR_BIT])
				ptr_next = ir_reg[NEW_PTR_BIT];
		end
	end

	assign fetch_aux = aux_next[ptr_next];
	assign rd_addr   = prog_data_in[IND_BIT] ? fetch_aux[DADDR_W-1:0]
		: prog_data_in[DADDR_W-1:0];

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			aux_reg[0] <= AUX_RESET;
			aux_reg[1] <= AUX_RESET;
			ptr_reg    <= 1'b0;
		end
		else
		begin
			aux_reg <= aux_next;
			ptr_reg <= ptr_next;
		end
	end

	// Sequencer: fill, run, then the two table-write cycles.
	always_comb
	begin
		case (state_reg)
			ST_FILL:     state_next = fetch_tw ? ST_TW_ADDR : ST_RUN;
			ST_RUN:      state_next = fetch_tw ? ST_TW_ADDR : ST_RUN;
			ST_TW_ADDR:  state_next = ST_TW_WRITE;
			ST_TW_WRITE: state_next = ST_FILL;
			default:     state_next = ST_FILL;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			state_reg <= ST_FILL;
		else
			state_reg <= state_next;
	end

	// Opcode fetch overlaps the execution of the previous instruction.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			ir_reg <= IR_RESET;
		else if (fetch_now)
			ir_reg <= prog_data_in;
	end

	// Program counter and return stack.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pc_reg <= PC_RESET;
			for (int i = 0; i < STACK_D; i++)
				stack_reg[i] <= PC_RESET;
		end
		else
		begin
			case (state_reg)
				ST_TW_ADDR:
				begin
					stack_reg[0] <= pc_reg;
					for (int i = 1; i < STACK_D; i++)
						stack_reg[i] <= stack_reg[i-1];
					pc_reg <= sum_reg[PC_W-1:0];
				end
				ST_TW_WRITE:
				begin
					pc_reg <= stack_reg[0];
					for (int i = 0; i < STACK_D - 1; i++)
						stack_reg[i] <= stack_reg[i+1];
				end
				default:
					pc_reg <= pc_reg + 12'h001;
			endcase
		end
	end

	// Sum register operations.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			sum_reg <= SUM_RESET;
		else if (exec_now)
		begin
			if (ir_reg == OP_CLEAR_SUM)
				sum_reg <= SUM_RESET;
			else if (ir_op == OP_XOR)
				sum_reg[WORD_W-1:0] <= sum_reg[WORD_W-1:0] ^ dmem_word;
			else if (ir_op == OP_ZERO_LOAD_H)
				sum_reg <= {dmem_word, 16'h0000};
			else if (ir_op == OP_ZERO_LOAD_L)
				sum_reg <= {16'h0000, dmem_word};
		end
	end

	data_word_ram #(
		.WIDTH (WORD_W),
		.DEPTH (DMEM_DEPTH),
		.AW    (DADDR_W)
	) u_dmem (
		.ref_clk (ref_clk),
		.wr_en   (dmem_load_en),
		.wr_addr (dmem_load_addr),
		.wr_data (dmem_load_data),
		.rd_en   (fetch_now),
		.rd_addr (rd_addr),
		.rd_data (dmem_word)
	);

	property p_tw_strobes;
		@(posedge ref_clk) disable iff (!arst_n)
		(fetch_now && fetch_tw) |=> (!memory_enable_n && write_enable_n)
			##1 (!write_enable_n && memory_enable_n) ##1 (!memory_enable_n && write_enable_n);
	endproperty
	a_tw_strobes: assert property (p_tw_strobes) else $error("table write strobes wrong");

	property p_tw_jump;
		@(posedge ref_clk) disable iff (!arst_n)
		(state_reg == ST_TW_ADDR) |=> (prog_addr == $past(sum_reg[PC_W-1:0]));
	endproperty
	a_tw_jump: assert property (p_tw_jump) else $error("jump to sum address missing");

	property p_tw_return;
		@(posedge ref_clk) disable iff (!arst_n)
		(state_reg == ST_TW_ADDR) |-> ##2 (prog_addr == $past(prog_addr, 2));
	endproperty
	a_tw_return: assert property (p_tw_return) else $error("return address not restored");

	property p_tw_drive;
		@(posedge ref_clk) disable iff (!arst_n)
		!write_enable_n |-> (prog_data_oe && memory_enable_n && $stable(prog_data_out));
	endproperty
	a_tw_drive: assert property (p_tw_drive) else $error("write cycle bus drive wrong");

	property p_prefetch;
		@(posedge ref_clk) disable iff (!arst_n)
		(state_reg == ST_TW_WRITE) |=> (!memory_enable_n && state_reg == ST_FILL)
			##1 (exec_now || state_reg == ST_TW_ADDR);
	endproperty
	a_prefetch: assert property (p_prefetch) else $error("prefetch after write missing");

	property p_xor_half;
		@(posedge ref_clk) disable iff (!arst_n)
		(exec_now && ir_op == OP_XOR) |=> (sum_reg[31:16] == $past(sum_reg[31:16]))
			&& (sum_reg[15:0] == ($past(sum_reg[15:0]) ^ $past(dmem_word)));
	endproperty
	a_xor_half: assert property (p_xor_half) else $error("exclusive-OR result wrong");

	property p_clear;
		@(posedge ref_clk) disable iff (!arst_n)
		(exec_now && ir_reg == OP_CLEAR_SUM) |=> (sum_register == 32'h00000000);
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not zero sum");

	property p_load_high;
		@(posedge ref_clk) disable iff (!arst_n)
		(exec_now && ir_op == OP_ZERO_LOAD_H) |=> (sum_register == {$past(dmem_word), 16'h0000});
	endproperty
	a_load_high: assert property (p_load_high) else $error("zero-load-high wrong");

	property p_load_low;
		@(posedge ref_clk) disable iff (!arst_n)
		(exec_now && ir_op == OP_ZERO_LOAD_L) |=> (sum_register == {16'h0000, $past(dmem_word)});
	endproperty
	a_load_low: assert property (p_load_low) else $error("zero-load-low wrong");

	property p_new_pointer;
		@(posedge ref_clk) disable iff (!arst_n)
		(exec_mem && ir_reg[IND_BIT] && !ir_reg[KEEP_PTR_BIT])
			|=> (aux_pointer_select == $past(ir_reg[NEW_PTR_BIT]));
	endproperty
	a_new_pointer: assert property (p_new_pointer) else $error("aux pointer not updated");

	c_table_write: cover property (@(posedge ref_clk) disable iff (!arst_n)
		(state_reg == ST_TW_ADDR) ##1 !write_enable_n);
	c_xor_run: cover property (@(posedge ref_clk) disable iff (!arst_n)
		(exec_now && ir_op == OP_XOR));
	c_xor_then_write: cover property (@(posedge ref_clk) disable iff (!arst_n)
		(exec_now && ir_op == OP_XOR) ##1 (state_reg == ST_TW_ADDR));
	c_back_to_back_write: cover property (@(posedge ref_clk) disable iff (!arst_n)
		(state_reg == ST_FILL) ##1 (state_reg == ST_TW_ADDR));
endmodule

/* tw_decode_pkg.sv */
// Package with opcodes, widths and reset values for the table-write decoder.
package tw_decode_pkg;
	localparam int PC_W          = 12;
	localparam int WORD_W        = 16;
	localparam int SUM_W         = 32;
	localparam int DADDR_W       = 7;
	localparam int AUX_W         = 8;
	localparam int STACK_DEPTH   = 4;
	localparam int DMEM_DEPTH    = 128;
	localparam int OP_HI         = 15;
	localparam int OP_LO         = 8;
	localparam int IND_BIT       = 7;
	localparam int INC_BIT       = 5;
	localparam int DEC_BIT       = 4;
	localparam int KEEP_PTR_BIT  = 3;
	localparam int NEW_PTR_BIT   = 0;
	localparam logic [7:0]  OP_TABLE_WRITE = 8'h7D;
	localparam logic [7:0]  OP_XOR         = 8'h78;
	localparam logic [7:0]  OP_ZERO_LOAD_H = 8'h65;
	localparam logic [7:0]  OP_ZERO_LOAD_L = 8'h66;
	localparam logic [15:0] OP_CLEAR_SUM   = 16'h7F89;
	localparam logic [11:0] PC_RESET       = 12'h000;
	localparam logic [31:0] SUM_RESET      = 32'h00000000;
	localparam logic [15:0] IR_RESET       = 16'h0000;
	localparam logic [7:0]  AUX_RESET      = 8'h00;
	typedef enum logic [1:0] {
		ST_FILL     = 2'b00,
		ST_RUN      = 2'b01,
		ST_TW_ADDR  = 2'b11,
		ST_TW_WRITE = 2'b10
	} seq_state_t;
endpackage
